// File: mtm_pkg.sv
// Constants for the motor thermal model and emergency override block.
// Assumes one 50 MHz clock, a sample tick from the measuring front end,
// and an AXI4-Lite master for the settings.
//
// Function
// - Short start spacing: cold after stopped one hour
// - Long start spacing: cold when spacing timer expires
// - Override forces cold state at once
// - Source select: off, input, softkey, either
// - Override source resets to disabled
// - Panel command also overrides at any source; input function only when selected
// - Override loads accumulator with 40 C level
// - Override restores full cold-start allowance
// - Override counted and logged with time stamp
// - Override clears and restarts all protection timers
// - Effective current squared: I1 squared plus weighted I2
// - Limit time from locked-rotor data above threshold
// - Stator temperature adds stator-to-rotor cooling term
// - Stator used only if winding, trip-enabled, valid
// - Stator capacity: temp/240 plus 50-second heating term
// - No trip while capacity below trip threshold
// - Winding trip function uses hottest winding sensor
// - Separate alarm and trip, delays, four groups
// - Cooling time constant sets accumulator decay
package mtm_pkg;

	// Sample tick rate and timing figures
	localparam logic [7:0] TICKS_PER_S = 8'h64;
	localparam logic [31:0] ONE_HOUR_S = 32'h0000_0E10;
	localparam logic [15:0] STATOR_DIV = 16'h00F0;
	localparam logic [7:0] LOSS_TAU_S = 8'h32;
	localparam logic [7:0] INIT_DIV = 8'h06;
	localparam logic [7:0] PERCENT_FULL = 8'h64;

	// Register byte offsets
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_ACC_LO = 8'h08;
	localparam logic [7:0] ADDR_ACC_HI = 8'h0C;
	localparam logic [7:0] ADDR_OVR_COUNT = 8'h10;
	localparam logic [7:0] ADDR_OVR_STAMP = 8'h14;
	localparam logic [7:0] ADDR_LRC = 8'h18;
	localparam logic [7:0] ADDR_STALL = 8'h1C;
	localparam logic [7:0] ADDR_NEGW = 8'h20;
	localparam logic [7:0] ADDR_HEAT_THR = 8'h24;
	localparam logic [7:0] ADDR_COOL = 8'h28;
	localparam logic [7:0] ADDR_TBS = 8'h2C;
	localparam logic [7:0] ADDR_WIND_CFG = 8'h30;
	localparam logic [7:0] ADDR_STATOR = 8'h34;
	// Setting groups: base + group*0x10 + field*4
	localparam logic [1:0] GROUP_AREA = 2'h1;
	localparam logic [1:0] GF_ALARM_THR = 2'h0;
	localparam logic [1:0] GF_TRIP_THR = 2'h1;
	localparam logic [1:0] GF_ALARM_DLY = 2'h2;
	localparam logic [1:0] GF_TRIP_DLY = 2'h3;

	// Control and winding configuration register fields
	localparam int CTRL_SRC_LSB = 0;
	localparam int CTRL_SOFTKEY = 2;
	localparam int CTRL_PANEL = 3;
	localparam int CTRL_ALARM_EN = 4;
	localparam int CTRL_TRIP_EN = 5;
	localparam int CTRL_GROUP_LSB = 6;
	localparam int WIND_TRIP_LSB = 4;
	localparam int WIND_FN = 8;
	localparam int NUM_WIND = 4;

	// Values after reset
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [15:0] LRC_RST = 16'h0600;
	localparam logic [15:0] STALL_RST = 16'h000F;
	localparam logic [15:0] NEGW_RST = 16'h0300;
	localparam logic [31:0] HEAT_THR_RST = 32'h0001_0000;
	localparam logic [4:0] COOL_RST = 5'h0A;
	localparam logic [31:0] TBS_RST = 32'h0000_0E10;
	localparam logic [8:0] WIND_RST = 9'h000;
	localparam logic [15:0] ALARM_THR_RST = 16'h0050;
	localparam logic [15:0] TRIP_THR_RST = 16'h0064;

	// Bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		MTM_SRC_OFF = 2'h0,
		MTM_SRC_INPUT = 2'h1,
		MTM_SRC_PANEL = 2'h2,
		MTM_SRC_EITHER = 2'h3
	} mtm_src_t;

endpackage : mtm_pkg

// File: mtm_thermal.sv
// Motor thermal model, cold/warm detection and emergency override.
// Assumes currents and temperatures come from same-clock logic and the
// override input function arrives from a pin.
//
// Local design decisions: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps

module mtm_delay_element (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Control
	input wire logic clear,
	input wire logic enable,
	input wire logic above,
	input wire logic tick,
	input wire logic [15:0] delay,
	// Result
	output logic fire
);
	logic [15:0] count;

	// Restart whenever capacity falls back or an override hits
	always_ff @(posedge aclk) begin
		if (!aresetn || clear || !enable || !above) begin
			count <= 16'h0000;
			fire <= 1'b0;
		end else if (!fire) begin
			if (count >= delay) begin
				fire <= 1'b1;
			end else if (tick) begin
				count <= count + 16'h0001;
			end
		end
	end
endmodule : mtm_delay_element

module mtm_thermal (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	// AXI4-Lite write data
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// AXI4-Lite write response
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Measurements: currents per-unit Q8.8, temperatures in whole degrees C
	input wire logic sample_tick,
	input wire logic [15:0] positive_seq_current,
	input wire logic [15:0] negative_seq_current,
	input wire logic [63:0] winding_sensor_temp,
	input wire logic [3:0] winding_sensor_valid,
	// Motor state and override pin
	input wire logic motor_stopped,
	input wire logic override_input_function,
	// Outcomes
	output logic cold_sequence,
	output logic thermal_alarm,
	output logic thermal_trip,
	output logic protection_restart,
	output logic override_event,
	output logic [31:0] override_time
);

	// Settings
	logic [31:0] ctrl;
	logic [15:0] locked_rotor_current;
	logic [15:0] allowable_stall_time;
	logic [15:0] negative_sequence_weight;
	logic [31:0] heat_threshold;
	logic [4:0] cool_shift;
	logic [31:0] start_spacing;
	logic [8:0] wind_cfg;
	logic [15:0] group_reg [16];
	logic softkey_pulse;
	logic panel_pulse;

	// Bus state
	logic aw_held;
	logic w_held;
	logic [7:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic do_write;
	logic [31:0] next_rdata;
	logic next_rerr;
	logic wr_mapped;

	// Model state
	logic [63:0] acc;
	logic [63:0] next_acc;
	logic [31:0] ovr_count;
	logic [7:0] tick_cnt;
	logic sec_pulse;
	logic [31:0] seconds;
	logic [31:0] stop_sec;
	logic stopped_q;
	logic ovr_sync1;
	logic ovr_sync2;
	logic ovr_prev;
	logic ovr_req;
	mtm_pkg::mtm_src_t src;

	// Derived arithmetic
	logic [31:0] i1_sq;
	logic [31:0] i2_sq;
	logic [47:0] i2_weighted;
	logic [40:0] ieff_sq;
	logic heating;
	logic [31:0] lrc_sq;
	logic [63:0] full;
	logic [63:0] init_level;
	logic [63:0] stator_level;
	logic [63:0] loss;
	logic [3:0] wind_qual;
	logic stator_use;
	logic [15:0] stator_temp;
	logic [1:0] group;
	logic [71:0] used_scaled;
	logic alarm_above;
	logic trip_above;
	logic [31:0] spacing_limit;

	localparam logic [63:0] LOSS_DIV = 64'(mtm_pkg::LOSS_TAU_S) * 64'(mtm_pkg::TICKS_PER_S);

	// AXI4-Lite write path: address and data taken in either order
	assign awready = !aw_held && !bvalid;
	assign wready = !w_held && !bvalid;
	assign arready = !rvalid;
	assign do_write = aw_held && w_held && !bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr_q <= 8'h00;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
			bvalid <= 1'b0;
			bresp <= mtm_pkg::RESP_OKAY;
		end else begin
			if (awvalid && awready) begin
				aw_held <= 1'b1;
				aw_addr_q <= awaddr;
			end
			if (wvalid && wready) begin
				w_held <= 1'b1;
				w_data_q <= wdata;
				w_strb_q <= wstrb;
			end
			if (do_write) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				bvalid <= 1'b1;
				bresp <= wr_mapped ? mtm_pkg::RESP_OKAY : mtm_pkg::RESP_SLVERR;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[b*8 +: 8] = val[b*8 +: 8];
			end
		end
		return res;
	endfunction : merge

	always_comb begin
		case (aw_addr_q)
			mtm_pkg::ADDR_CTRL, mtm_pkg::ADDR_STATUS, mtm_pkg::ADDR_ACC_LO,
			mtm_pkg::ADDR_ACC_HI, mtm_pkg::ADDR_OVR_COUNT, mtm_pkg::ADDR_OVR_STAMP,
			mtm_pkg::ADDR_LRC, mtm_pkg::ADDR_STALL, mtm_pkg::ADDR_NEGW,
			mtm_pkg::ADDR_HEAT_THR, mtm_pkg::ADDR_COOL, mtm_pkg::ADDR_TBS,
			mtm_pkg::ADDR_WIND_CFG, mtm_pkg::ADDR_STATOR: wr_mapped = 1'b1;
			default: wr_mapped = (aw_addr_q[7:6] == mtm_pkg::GROUP_AREA);
		endcase
	end

	// Settings registers; read-only addresses ignore writes
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl <= mtm_pkg::CTRL_RST;
			locked_rotor_current <= mtm_pkg::LRC_RST;
			allowable_stall_time <= mtm_pkg::STALL_RST;
			negative_sequence_weight <= mtm_pkg::NEGW_RST;
			heat_threshold <= mtm_pkg::HEAT_THR_RST;
			cool_shift <= mtm_pkg::COOL_RST;
			start_spacing <= mtm_pkg::TBS_RST;
			wind_cfg <= mtm_pkg::WIND_RST;
			softkey_pulse <= 1'b0;
			panel_pulse <= 1'b0;
			for (int g = 0; g < 16; g++) begin
				group_reg[g] <= g[1:0] == mtm_pkg::GF_ALARM_THR ? mtm_pkg::ALARM_THR_RST :
					g[1:0] == mtm_pkg::GF_TRIP_THR ? mtm_pkg::TRIP_THR_RST : 16'h0000;
			end
		end else begin
			softkey_pulse <= 1'b0;
			panel_pulse <= 1'b0;
			if (do_write) begin
				case (aw_addr_q)
					mtm_pkg::ADDR_CTRL: begin
						ctrl <= merge(ctrl, {w_data_q[31:4], 2'h0, w_data_q[1:0]}, w_strb_q);
						softkey_pulse <= w_strb_q[0] && w_data_q[mtm_pkg::CTRL_SOFTKEY];
						panel_pulse <= w_strb_q[0] && w_data_q[mtm_pkg::CTRL_PANEL];
					end
					mtm_pkg::ADDR_LRC: locked_rotor_current <=
						16'(merge({16'h0000, locked_rotor_current}, w_data_q, w_strb_q));
					mtm_pkg::ADDR_STALL: allowable_stall_time <=
						16'(merge({16'h0000, allowable_stall_time}, w_data_q, w_strb_q));
					mtm_pkg::ADDR_NEGW: negative_sequence_weight <=
						16'(merge({16'h0000, negative_sequence_weight}, w_data_q, w_strb_q));
					mtm_pkg::ADDR_HEAT_THR: heat_threshold <=
						merge(heat_threshold, w_data_q, w_strb_q);
					mtm_pkg::ADDR_COOL: cool_shift <=
						5'(merge({27'h0, cool_shift}, w_data_q, w_strb_q));
					mtm_pkg::ADDR_TBS: start_spacing <= merge(start_spacing, w_data_q, w_strb_q);
					mtm_pkg::ADDR_WIND_CFG: wind_cfg <=
						9'(merge({23'h0, wind_cfg}, w_data_q, w_strb_q));
					default: begin
						if (aw_addr_q[7:6] == mtm_pkg::GROUP_AREA) begin
							group_reg[aw_addr_q[5:2]] <=
								16'(merge({16'h0000, group_reg[aw_addr_q[5:2]]}, w_data_q, w_strb_q));
						end
					end
				endcase
			end
		end
	end

	// AXI4-Lite read path
	always_comb begin
		next_rerr = 1'b0;
		case (araddr)
			mtm_pkg::ADDR_CTRL: next_rdata = ctrl;
			mtm_pkg::ADDR_STATUS: next_rdata = {27'h0, stopped_q, stator_use,
				thermal_trip, thermal_alarm, cold_sequence};
			mtm_pkg::ADDR_ACC_LO: next_rdata = acc[31:0];
			mtm_pkg::ADDR_ACC_HI: next_rdata = acc[63:32];
			mtm_pkg::ADDR_OVR_COUNT: next_rdata = ovr_count;
			mtm_pkg::ADDR_OVR_STAMP: next_rdata = override_time;
			mtm_pkg::ADDR_LRC: next_rdata = {16'h0000, locked_rotor_current};
			mtm_pkg::ADDR_STALL: next_rdata = {16'h0000, allowable_stall_time};
			mtm_pkg::ADDR_NEGW: next_rdata = {16'h0000, negative_sequence_weight};
			mtm_pkg::ADDR_HEAT_THR: next_rdata = heat_threshold;
			mtm_pkg::ADDR_COOL: next_rdata = {27'h0, cool_shift};
			mtm_pkg::ADDR_TBS: next_rdata = start_spacing;
			mtm_pkg::ADDR_WIND_CFG: next_rdata = {23'h0, wind_cfg};
			mtm_pkg::ADDR_STATOR: next_rdata = {16'h0000, stator_temp};
			default: begin
				next_rdata = 32'h0000_0000;
				next_rerr = 1'b1;
				if (araddr[7:6] == mtm_pkg::GROUP_AREA) begin
					next_rdata = {16'h0000, group_reg[araddr[5:2]]};
					next_rerr = 1'b0;
				end
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= mtm_pkg::RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			rdata <= next_rdata;
			rresp <= next_rerr ? mtm_pkg::RESP_SLVERR : mtm_pkg::RESP_OKAY;
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
		end
	end

	// Pin synchroniser; edge taken only from the second stage
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ovr_sync1 <= 1'b0;
			ovr_sync2 <= 1'b0;
			ovr_prev <= 1'b0;
		end else begin
			ovr_sync1 <= override_input_function;
			ovr_sync2 <= ovr_sync1;
			ovr_prev <= ovr_sync2;
		end
	end

	// Override sources; panel reset command is always accepted
	assign src = mtm_pkg::mtm_src_t'(ctrl[mtm_pkg::CTRL_SRC_LSB +: 2]);
	assign ovr_req = (ovr_sync2 && !ovr_prev &&
			(src == mtm_pkg::MTM_SRC_INPUT || src == mtm_pkg::MTM_SRC_EITHER)) ||
		(softkey_pulse && (src == mtm_pkg::MTM_SRC_PANEL || src == mtm_pkg::MTM_SRC_EITHER)) ||
		panel_pulse;

	// Effective heating current, Q16.16 per-unit squared
	assign i1_sq = 32'(positive_seq_current) * 32'(positive_seq_current);
	assign i2_sq = 32'(negative_seq_current) * 32'(negative_seq_current);
	assign i2_weighted = 48'(i2_sq) * 48'(negative_sequence_weight);
	assign ieff_sq = 41'(i1_sq) + 41'(i2_weighted[47:8]);
	assign heating = ieff_sq > 41'(heat_threshold);

	// Full capacity in accumulator units: locked-rotor current squared times stall time times tick rate
	assign lrc_sq = 32'(locked_rotor_current) * 32'(locked_rotor_current);
	assign full = 64'(lrc_sq) * 64'(allowable_stall_time) * 64'(mtm_pkg::TICKS_PER_S);
	assign init_level = full / 64'(mtm_pkg::INIT_DIV);

	// Stator temperature selection
	always_comb begin
		stator_temp = 16'h0000;
		for (int k = 0; k < mtm_pkg::NUM_WIND; k++) begin
			wind_qual[k] = wind_cfg[k] && wind_cfg[mtm_pkg::WIND_TRIP_LSB + k] &&
				winding_sensor_valid[k];
		end
		for (int k = mtm_pkg::NUM_WIND - 1; k >= 0; k--) begin
			if (wind_qual[k]) begin
				if (!wind_cfg[mtm_pkg::WIND_FN]) begin
					stator_temp = winding_sensor_temp[k*16 +: 16];
				end else if ($signed(winding_sensor_temp[k*16 +: 16]) > $signed(stator_temp)) begin
					stator_temp = winding_sensor_temp[k*16 +: 16];
				end
			end
		end
		if (stator_temp[15]) begin
			stator_temp = 16'h0000;
		end
	end
	assign stator_use = |wind_qual;

	// Stator term gives steady state temp/240 plus 50 s heating share
	assign stator_level = 64'((80'(full) * 80'(stator_temp)) / 80'(mtm_pkg::STATOR_DIV));
	assign loss = (stator_use && acc > stator_level) ? (acc - stator_level) / LOSS_DIV :
		64'h0;

	always_comb begin
		next_acc = acc;
		if (heating) begin
			next_acc = acc + 64'(ieff_sq) - loss;
		end else if (acc > init_level) begin
			next_acc = acc - ((acc - init_level) >> cool_shift);
		end else begin
			next_acc = acc + ((init_level - acc) >> cool_shift);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			acc <= 64'h0;
		end else if (ovr_req) begin
			acc <= init_level;
		end else if (sample_tick) begin
			acc <= next_acc;
		end
	end

	// Seconds from the sample tick
	assign sec_pulse = sample_tick && (tick_cnt == mtm_pkg::TICKS_PER_S - 8'h01);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tick_cnt <= 8'h00;
			seconds <= 32'h0;
		end else if (sample_tick) begin
			tick_cnt <= sec_pulse ? 8'h00 : tick_cnt + 8'h01;
			if (sec_pulse) begin
				seconds <= seconds + 32'h1;
			end
		end
	end

	// Stop time; override presents a long-idle motor
	assign spacing_limit = (start_spacing < mtm_pkg::ONE_HOUR_S) ? mtm_pkg::ONE_HOUR_S :
		start_spacing;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stop_sec <= 32'h0;
			stopped_q <= 1'b0;
		end else begin
			stopped_q <= motor_stopped;
			if (ovr_req) begin
				stop_sec <= spacing_limit + 32'h1;
			end else if (!motor_stopped) begin
				stop_sec <= 32'h0;
			end else if (sec_pulse && stop_sec != 32'hFFFF_FFFF) begin
				stop_sec <= stop_sec + 32'h1;
			end
		end
	end

	// Cold sequence ends when the motor starts
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cold_sequence <= 1'b0;
		end else if (ovr_req) begin
			cold_sequence <= 1'b1;
		end else if (motor_stopped && !stopped_q) begin
			cold_sequence <= cold_sequence;
		end else if (!motor_stopped && stopped_q) begin
			cold_sequence <= 1'b0;
		end else if (motor_stopped && start_spacing < mtm_pkg::ONE_HOUR_S &&
				stop_sec > mtm_pkg::ONE_HOUR_S) begin
			cold_sequence <= 1'b1;
		end else if (motor_stopped && start_spacing >= mtm_pkg::ONE_HOUR_S &&
				stop_sec >= start_spacing) begin
			cold_sequence <= 1'b1;
		end
	end

	// Override history, time stamp and restart strobe
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ovr_count <= 32'h0;
			override_time <= 32'h0;
			override_event <= 1'b0;
			protection_restart <= 1'b0;
		end else begin
			override_event <= ovr_req;
			protection_restart <= ovr_req;
			if (ovr_req) begin
				ovr_count <= ovr_count + 32'h1;
				override_time <= seconds;
			end
		end
	end

	// Alarm and trip from the active group
	assign group = ctrl[mtm_pkg::CTRL_GROUP_LSB +: 2];
	assign used_scaled = 72'(acc) * 72'(mtm_pkg::PERCENT_FULL);
	assign alarm_above = used_scaled >= 72'(full) * 72'(group_reg[{group, mtm_pkg::GF_ALARM_THR}]);
	assign trip_above = used_scaled >= 72'(full) * 72'(group_reg[{group, mtm_pkg::GF_TRIP_THR}]);

	mtm_delay_element u_alarm (
		.aclk(aclk),
		.aresetn(aresetn),
		.clear(ovr_req),
		.enable(ctrl[mtm_pkg::CTRL_ALARM_EN]),
		.above(alarm_above),
		.tick(sample_tick),
		.delay(group_reg[{group, mtm_pkg::GF_ALARM_DLY}]),
		.fire(thermal_alarm)
	);

	mtm_delay_element u_trip (
		.aclk(aclk),
		.aresetn(aresetn),
		.clear(ovr_req),
		.enable(ctrl[mtm_pkg::CTRL_TRIP_EN]),
		.above(trip_above),
		.tick(sample_tick),
		.delay(group_reg[{group, mtm_pkg::GF_TRIP_DLY}]),
		.fire(thermal_trip)
	);

endmodule : mtm_thermal

// File: mtm_thermal_asserts.sv
// Port checker for the thermal model block.
// Bound to mtm_thermal; sees its ports only, one clock domain.
`timescale 1ns/1ps
module mtm_thermal_checker (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Register bus
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	input wire logic rready,
	// Motor and outcomes
	input wire logic motor_stopped,
	input wire logic cold_sequence,
	input wire logic thermal_alarm,
	input wire logic thermal_trip,
	input wire logic protection_restart,
	input wire logic override_event,
	input wire logic [31:0] override_time
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	write_resp_a: assert property (awvalid && awready && wvalid && wready |-> ##[1:3] bvalid)
		else $error("write not answered");
	bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write answer dropped");
	rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable({rdata, rresp}))
		else $error("read answer dropped");
	read_answer_a: assert property (arvalid && arready |=> rvalid)
		else $error("read not answered");
	bus_block_a: assert property ((bvalid |-> !awready && !wready) and (rvalid |-> !arready))
		else $error("ready while answer pending");
	override_state_a: assert property (
		override_event |-> cold_sequence && !thermal_trip && !thermal_alarm && protection_restart)
		else $error("override left state behind");
	restart_pulse_a: assert property (protection_restart |-> override_event ##1 !protection_restart)
		else $error("restart pulse wrong");
	stamp_move_a: assert property ($changed(override_time) |-> override_event)
		else $error("stamp moved without override");
	cold_clear_a: assert property ($fell(motor_stopped) |-> ##[1:2] !cold_sequence)
		else $error("cold kept after start");
endmodule : mtm_thermal_checker

bind mtm_thermal mtm_thermal_checker chk (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
	.awready(awready), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
	.bready(bready), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
	.rvalid(rvalid), .rready(rready), .motor_stopped(motor_stopped),
	.cold_sequence(cold_sequence), .thermal_alarm(thermal_alarm), .thermal_trip(thermal_trip),
	.protection_restart(protection_restart), .override_event(override_event),
	.override_time(override_time));

// File: mtm_field.sv
// Field side model: sequence currents, winding sensors, stop state, pin.
// Assumes the bench sets load level, stop state and pin level.
`timescale 1ns/1ps
module mtm_field (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Bench control
	input wire logic [15:0] load,
	input wire logic stopped,
	input wire logic pin_level,
	// Toward the block
	output logic sample_tick,
	output logic [15:0] positive_seq_current,
	output logic [15:0] negative_seq_current,
	output logic [63:0] winding_sensor_temp,
	output logic [3:0] winding_sensor_valid,
	output logic motor_stopped,
	output logic override_input_function
);
	logic [1:0] div;

	// Tick every fourth cycle keeps heating runs short
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div <= 2'h0;
		end else begin
			div <= div + 2'h1;
		end
	end
	assign sample_tick = (div == 2'h3);
	// Half the load as negative sequence exercises the weight
	assign positive_seq_current = load;
	assign negative_seq_current = {1'b0, load[15:1]};
	// Distinct readings so the hottest one is telling
	assign winding_sensor_temp = {16'h0082, 16'h0078, 16'h006E, 16'h0064};
	assign winding_sensor_valid = 4'hF;
	assign motor_stopped = stopped;
	assign override_input_function = pin_level;
endmodule : mtm_field

// File: test_motor_thermal_model_override.sv
// Self-checking bench for the thermal model block.
// Assumes the field model drives measurements; bench is bus master.
`timescale 1ns/1ps
module test_motor_thermal_model_override;
	typedef struct {logic [7:0] a; logic [31:0] d; logic [1:0] r;} mtm_row_t;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic pin = 1'b0, stopped = 1'b1;
	logic [15:0] load = 16'h0000;
	logic awready, wready, bvalid, arready, rvalid, tick, mstop, ovr_pin;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata, override_time;
	logic [15:0] i1, i2;
	logic [63:0] temps;
	logic [3:0] tvalid;
	logic cold_sequence, thermal_alarm, thermal_trip, protection_restart, override_event;
	int n_fail = 0, n_compared = 0;
	mtm_row_t rows[12] = '{'{8'h00, 32'h0, 2'h0}, '{8'h18, 32'h600, 2'h0},
		'{8'h1C, 32'hF, 2'h0}, '{8'h20, 32'h300, 2'h0}, '{8'h24, 32'h10000, 2'h0},
		'{8'h28, 32'hA, 2'h0}, '{8'h2C, 32'hE10, 2'h0}, '{8'h30, 32'h0, 2'h0},
		'{8'h40, 32'h50, 2'h0}, '{8'h44, 32'h64, 2'h0}, '{8'h10, 32'h0, 2'h0},
		'{8'hFC, 32'h0, 2'h2}};

	always #10 aclk = ~aclk;

	mtm_field field (.aclk(aclk), .aresetn(aresetn), .load(load), .stopped(stopped),
		.pin_level(pin), .sample_tick(tick), .positive_seq_current(i1),
		.negative_seq_current(i2), .winding_sensor_temp(temps), .winding_sensor_valid(tvalid),
		.motor_stopped(mstop), .override_input_function(ovr_pin));

	mtm_thermal uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.sample_tick(tick), .positive_seq_current(i1), .negative_seq_current(i2),
		.winding_sensor_temp(temps), .winding_sensor_valid(tvalid), .motor_stopped(mstop),
		.override_input_function(ovr_pin), .cold_sequence(cold_sequence),
		.thermal_alarm(thermal_alarm), .thermal_trip(thermal_trip),
		.protection_restart(protection_restart), .override_event(override_event),
		.override_time(override_time));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask : chk

	task automatic end_of_test;
		if (n_fail == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : end_of_test

	// Ready is raised late on purpose so answers must wait
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic ad;
		logic wd;
		@(posedge aclk);
		ad = 1'b0;
		wd = 1'b0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(ad && wd)) begin
			@(posedge aclk);
			if (awvalid && awready) begin
				ad = 1'b1;
				awvalid <= 1'b0;
			end
			if (wvalid && wready) begin
				wd = 1'b1;
				wvalid <= 1'b0;
			end
		end
		while (!bvalid) @(posedge aclk);
		bready <= 1'b1;
		@(posedge aclk);
		r = bresp;
		bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'b0;
		while (!rvalid) @(posedge aclk);
		rready <= 1'b1;
		@(posedge aclk);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : rd

	initial begin
		repeat (10000) @(posedge aclk);
		n_fail++;
		end_of_test();
	end

	initial begin
		logic [31:0] d;
		logic [1:0] r;
		int cnt;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		foreach (rows[i]) begin
			rd(rows[i].a, d, r);
			chk(d, rows[i].d);
			chk({30'h0, r}, {30'h0, rows[i].r});
		end
		wr(8'hFC, 32'h0, r);
		chk({30'h0, r}, {30'h0, mtm_pkg::RESP_SLVERR});
		// Panel command with source disabled
		wr(mtm_pkg::ADDR_CTRL, 32'h08, r);
		repeat (4) @(posedge aclk);
		rd(mtm_pkg::ADDR_OVR_COUNT, d, r);
		chk(d, 32'h1);
		rd(mtm_pkg::ADDR_ACC_LO, d, r);
		chk(d, 32'h2328_0000);
		// Alarm 40 %, trip 50 %, five-tick delays, 8 pu load
		wr(8'h40, 32'h28, r);
		wr(8'h44, 32'h32, r);
		wr(8'h48, 32'h5, r);
		wr(8'h4C, 32'h5, r);
		wr(mtm_pkg::ADDR_CTRL, 32'h30, r);
		load <= 16'h0800;
		repeat (400) @(posedge aclk);
		chk({30'h0, thermal_alarm, thermal_trip}, 32'h0);
		repeat (160) @(posedge aclk);
		chk({30'h0, thermal_alarm, thermal_trip}, 32'h2);
		repeat (200) @(posedge aclk);
		chk({30'h0, thermal_alarm, thermal_trip}, 32'h3);
		load <= 16'h0000;
		wr(mtm_pkg::ADDR_CTRL, 32'h38, r);
		repeat (4) @(posedge aclk);
		chk({30'h0, thermal_alarm, thermal_trip}, 32'h0);
		rd(mtm_pkg::ADDR_ACC_LO, d, r);
		chk(d, 32'h2328_0000);
		// Group 1 alarm at 0 % with no delay; trip disabled and stays quiet
		wr(8'h50, 32'h0, r);
		wr(mtm_pkg::ADDR_CTRL, 32'h50, r);
		repeat (2) @(posedge aclk);
		chk({30'h0, thermal_alarm, thermal_trip}, 32'h2);
		// Each source setting against softkey and pin
		cnt = 2;
		for (int s = 0; s < 8; s++) begin
			wr(mtm_pkg::ADDR_CTRL, {30'h0, s[1:0]}, r);
			if (s[2]) begin
				pin <= 1'b1;
				repeat (6) @(posedge aclk);
				pin <= 1'b0;
			end else begin
				wr(mtm_pkg::ADDR_CTRL, {29'h0, 1'b1, s[1:0]}, r);
			end
			repeat (6) @(posedge aclk);
			cnt += s[2] ? s[0] : s[1];
			rd(mtm_pkg::ADDR_OVR_COUNT, d, r);
			chk(d, 32'(cnt));
		end
		wr(mtm_pkg::ADDR_WIND_CFG, 32'h1FF, r);
		rd(mtm_pkg::ADDR_STATOR, d, r);
		chk(d, 32'h82);
		wr(mtm_pkg::ADDR_WIND_CFG, 32'h00F, r);
		rd(mtm_pkg::ADDR_STATUS, d, r);
		chk({31'h0, d[3]}, 32'h0);
		chk({31'h0, cold_sequence}, 32'h1);
		stopped <= 1'b0;
		repeat (4) @(posedge aclk);
		chk({31'h0, cold_sequence}, 32'h0);
		// Heat a little, then zero shift lands on the initial level in one tick
		load <= 16'h0800;
		wr(mtm_pkg::ADDR_COOL, 32'h0, r);
		load <= 16'h0000;
		repeat (8) @(posedge aclk);
		rd(mtm_pkg::ADDR_ACC_LO, d, r);
		chk(d, 32'h2328_0000);
		end_of_test();
	end
endmodule : test_motor_thermal_model_override
